// >>> verilog/pt_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "pt_defines.svh"

module pt_timer
  import pt_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ext_reset_input,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  output var  logic       pwm_out
);

  pt_state_t q;
  pt_state_t n;

  pt_kind_t  kind;
  logic      on_s;
  logic      ext;
  logic      hit;
  logic      on_rise;
  logic      adv;
  logic      clr;
  logic      start;
  logic      match;
  logic      active;
  logic      gate_ok;

  pt_sync_if #(.W(2)) sif ();

  // Classify a mode code; anything not listed behaves as reserved.
  function automatic pt_kind_t kind_of(input logic [4:0] m);
    pt_kind_t k;
    k = PT_K_RSVD;
    case (m)
      `PT_M_SWGATE:    k = PT_K_FREE;
      `PT_M_GATE_HI:   k = PT_K_GATE;
      `PT_M_GATE_LO:   k = PT_K_GATE;
      `PT_M_EDGE_ANY:  k = PT_K_EDGE;
      `PT_M_EDGE_RISE: k = PT_K_EDGE;
      `PT_M_EDGE_FALL: k = PT_K_EDGE;
      `PT_M_LVL_LOW:   k = PT_K_LEVEL;
      `PT_M_LVL_HIGH:  k = PT_K_LEVEL;
      `PT_M_OS_SW:     k = PT_K_OS;
      `PT_M_OS_RISE:   k = PT_K_EOS;
      `PT_M_OS_FALL:   k = PT_K_EOS;
      `PT_M_OS_ANY:    k = PT_K_EOS;
      default:         k = PT_K_RSVD;
    endcase
    return k;
  endfunction

  // Select the external edge that acts in the current mode.
  function automatic logic edge_hit(input logic [4:0] m,
                                    input logic       r,
                                    input logic       f);
    logic h;
    h = 1'b0;
    case (m)
      `PT_M_EDGE_ANY:  h = r | f;
      `PT_M_OS_ANY:    h = r | f;
      `PT_M_EDGE_RISE: h = r;
      `PT_M_OS_RISE:   h = r;
      `PT_M_EDGE_FALL: h = f;
      `PT_M_OS_FALL:   h = f;
      default:         h = 1'b0;
    endcase
    return h;
  endfunction

  // Both the external input and the run bit go through the synchroniser,
  // so the timer sees the run bit some clocks after software writes it.
  assign sif.raw[`PT_SYNC_EXT] = ext_reset_input; // R20
  assign sif.raw[`PT_SYNC_ON]  = q.on; // R20

  pt_sync #(
    .W (2)
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .sif  (sif)
  );

  // Next-state logic: mode sequencing, counter, PWM and register port.
  always_comb begin
    n       = q;
    kind    = kind_of(q.mode);
    on_s    = sif.lvl[`PT_SYNC_ON];
    ext     = sif.lvl[`PT_SYNC_EXT];
    hit     = edge_hit(q.mode, sif.rise[`PT_SYNC_EXT],
                       sif.fall[`PT_SYNC_EXT]);
    on_rise = on_s & ~q.on_prev;
    adv     = 1'b0;
    clr     = 1'b0;
    start   = 1'b0;
    active  = 1'b0;
    gate_ok = 1'b1;
    n.on_prev = on_s;

    // A stopped timer drops its arming, delays and one-shot latch.
    if (!on_s) begin
      n.armed = 1'b0; // R21
      n.dly   = `PT_ZERO2; // R21
      n.act   = `PT_ZERO2; // R21
      n.done  = 1'b0; // R21
    end

    unique case (kind)
      PT_K_FREE, PT_K_GATE: begin
        if (kind == PT_K_GATE) begin
          gate_ok = (q.mode == `PT_M_GATE_HI) ? ~ext : ext; // R3
        end
        adv   = on_s & gate_ok; // R1
        start = on_rise;
      end
      PT_K_EDGE: begin
        if (on_s) begin
          if (hit) begin
            clr   = 1'b1; // R5
            n.dly = `PT_RESTART_DLY; // R6
          end else if (q.dly != `PT_ZERO2) begin
            n.dly = q.dly - `PT_ONE2;
            start = (q.dly == `PT_ONE2); // R6
          end else begin
            adv = 1'b1;
          end
          if (on_rise) begin
            start = 1'b1;
          end
        end
      end
      PT_K_LEVEL: begin
        // Only a running timer looks at the level at all.
        if (on_s) begin // R8
          active = (q.mode == `PT_M_LVL_LOW) ? ~ext : ext; // R7
          if (active && q.act == `PT_LEVEL_DLY) begin
            clr   = 1'b1; // R9
            n.dly = `PT_RESTART_DLY; // R10
          end else if (active) begin
            n.act = q.act + `PT_ONE2; // R9
            adv   = (q.dly == `PT_ZERO2);
          end else if (q.dly != `PT_ZERO2) begin
            n.act = `PT_ZERO2;
            n.dly = q.dly - `PT_ONE2;
            start = (q.dly == `PT_ONE2); // R10 R11
          end else begin
            n.act = `PT_ZERO2;
            adv   = 1'b1;
          end
          if (on_rise && !active) begin
            start = 1'b1; // R11
          end
        end
      end
      PT_K_OS: begin
        // A pause keeps the count; only a fresh cycle from zero
        // raises the drive again.
        adv   = on_s & ~q.done; // R15
        start = on_rise & ~q.done & (q.cnt == `PT_ZERO8); // R16
      end
      PT_K_EOS: begin
        if (on_s && !q.done) begin
          if (!q.armed) begin
            if (hit) begin
              n.armed = 1'b1; // R17 R18
              start   = 1'b1; // R19
            end
          end else begin
            adv = 1'b1; // R17
          end
        end
      end
      PT_K_RSVD: begin
        adv = 1'b0; // R23
      end
    endcase

    // Counter: early reset first, then period match, then increment.
    match = adv & (q.cnt == q.per);
    if (clr) begin
      n.cnt = `PT_ZERO8; // R5 R7
    end else if (match) begin
      n.cnt = `PT_ZERO8; // R2
      if (kind == PT_K_OS || kind == PT_K_EOS) begin
        n.on    = 1'b0; // R13 R17 R22
        n.done  = 1'b1; // R22
        n.armed = 1'b0;
      end else begin
        start = 1'b1; // R10
      end
    end else if (adv) begin
      n.cnt = q.cnt + 8'h01; // R1
    end

    // PWM drive: a start raises it, compare lowers it; halts leave it be,
    // which is what stretches the period and the high time.
    if (kind == PT_K_RSVD) begin
      n.pwm = 1'b0; // R23
    end else if (start) begin
      n.pwm = 1'b1; // R11 R16 R19
    end else if (q.cnt == q.cmp) begin // R4
      n.pwm = 1'b0; // R11 R12 R19
    end

    // Register reads answer one cycle later; reserved bits read zero.
    n.rdata = `PT_ZERO8;
    if (reg_rd) begin
      unique case (reg_addr)
        `PT_ADDR_CTRL: begin
          n.rdata[`PT_CTRL_ON] = q.on;
          n.rdata[`PT_MODE_MSB:`PT_MODE_LSB] = q.mode;
        end
        `PT_ADDR_PERIOD: n.rdata = q.per;
        `PT_ADDR_CMP:    n.rdata = q.cmp;
        `PT_ADDR_COUNT:  n.rdata = q.cnt;
      endcase
    end

    // Software writes come last so they win over the hardware clear.
    if (reg_wr) begin
      unique case (reg_addr)
        `PT_ADDR_CTRL: begin
          n.on   = reg_wdata[`PT_CTRL_ON];
          n.mode = reg_wdata[`PT_MODE_MSB:`PT_MODE_LSB];
        end
        `PT_ADDR_PERIOD: n.per = reg_wdata;
        `PT_ADDR_CMP:    n.cmp = reg_wdata;
        `PT_ADDR_COUNT:  n.cnt = reg_wdata;
      endcase
    end
  end

  // Single register for the whole state.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata = q.rdata;
  assign pwm_out   = q.pwm;

  default clocking cb @(posedge mclk);
  endclocking

  default disable iff (rst);

  sw_gate_hold_a: assert property ( // R1
    (q.mode == `PT_M_SWGATE && !on_s && !reg_wr) |=> $stable(q.cnt))
    else $error("Counter moved while software gate was stopped.");

  // A zero period makes every clock a match, so that case may sit at
  // zero instead of stepping on to one.
  period_wrap_a: assert property ( // R2
    (kind == PT_K_FREE && on_s && q.cnt == q.per && !reg_wr)
      |=> (q.cnt == `PT_ZERO8)
      ##1 (q.cnt == 8'h01 || q.per == `PT_ZERO8 || !on_s))
    else $error("Counter did not wrap to zero after period match.");

  gate_halt_a: assert property ( // R3
    (q.mode == `PT_M_GATE_HI && ext && !reg_wr) |=> $stable(q.cnt))
    else $error("Active-high gate let the counter move.");

  gate_pwm_a: assert property ( // R4
    (kind == PT_K_GATE && !gate_ok && q.pwm && q.cnt != q.cmp
      && !reg_wr) |=> q.pwm)
    else $error("Gate halt dropped a high PWM output.");

  edge_reset_a: assert property ( // R5
    (kind == PT_K_EDGE && on_s && hit && !reg_wr)
      |=> (q.cnt == `PT_ZERO8 && q.dly == `PT_RESTART_DLY))
    else $error("Edge reset did not clear the counter.");

  restart_pwm_a: assert property ( // R6
    (kind == PT_K_EDGE && on_s && hit)
      ##1 (kind == PT_K_EDGE && on_s && !hit)[*2] |=> q.pwm)
    else $error("PWM not restarted two clocks after edge reset.");

  level_reset_a: assert property ( // R9
    (kind == PT_K_LEVEL && on_s && active && q.act == `PT_LEVEL_DLY
      && !reg_wr) |=> (q.cnt == `PT_ZERO8))
    else $error("Level reset did not hold the counter at zero.");

  level_ignore_a: assert property ( // R8
    (kind == PT_K_LEVEL && !on_s && !reg_wr) |=> $stable(q.cnt))
    else $error("Level mode reacted while the run bit was clear.");

  oneshot_end_a: assert property ( // R22
    (kind == PT_K_OS && on_s && !q.done && q.cnt == q.per && !reg_wr)
      |=> (q.cnt == `PT_ZERO8 && !q.on && q.done))
    else $error("One-shot end did not clear run bit and counter.");

  rearm_a: assert property ( // R18
    (kind == PT_K_EOS && !on_s) |=> !q.armed)
    else $error("Edge one-shot stayed armed after the run bit fell.");

  reserved_idle_a: assert property ( // R23
    (kind == PT_K_RSVD && !reg_wr) |=> ($stable(q.cnt) && !q.pwm))
    else $error("Reserved mode moved the counter or drove PWM.");

  gate_low_a: assert property ( // R3
    (q.mode == `PT_M_GATE_LO && !ext && !reg_wr) |=> $stable(q.cnt))
    else $error("Active-low gate let the counter move.");

  edge_hold_a: assert property ( // R6
    (kind == PT_K_EDGE && on_s && !hit && q.dly != `PT_ZERO2
      && !reg_wr) |=> $stable(q.cnt))
    else $error("Counter moved during the restart delay.");

  level_start_a: assert property ( // R11
    (kind == PT_K_LEVEL && on_s && !active && q.dly == `PT_ONE2)
      |=> q.pwm)
    else $error("Level release did not raise the PWM output.");

  oneshot_pause_a: assert property ( // R15
    (kind == PT_K_OS && !on_s && !reg_wr) |=> $stable(q.cnt))
    else $error("Paused one-shot counter moved.");

  oneshot_pwm_a: assert property ( // R16
    (kind == PT_K_OS && on_rise && !q.done && q.cnt == `PT_ZERO8)
      |=> q.pwm)
    else $error("One-shot start did not raise the PWM output.");

  eos_wait_a: assert property ( // R17
    (kind == PT_K_EOS && !q.armed && !reg_wr) |=> $stable(q.cnt))
    else $error("Edge one-shot counted before its starting edge.");

  eos_start_a: assert property ( // R19
    (kind == PT_K_EOS && on_s && !q.done && !q.armed && hit)
      |=> (q.pwm && q.armed))
    else $error("Starting edge did not arm the timer and raise PWM.");

  // The level only moves once two late stages agree, so the pin must
  // have been high three and four clocks before the rise is seen.
  ext_sync_a: assert property ( // R20
    $rose(ext) |-> ($past(ext_reset_input, 3)
      && $past(ext_reset_input, 4)))
    else $error("External input reached the timer too early.");

endmodule // pt_timer

`default_nettype wire

// >>> verilog/pt_defines.svh
// Operation
// R1 - Software gate mode counts each clock while running, holds while stopped.
// R2 - Count equal to period wraps to zero next clock, then keeps counting.
// R3 - Gate modes halt counting while the external input is high or low.
// R4 - Gating halts stretch the PWM period and, if high, its high time.
// R5 - Edge limit modes reset the counter early on the selected input edge.
// R6 - After an early reset the next PWM pulse starts two clocks later.
// R7 - Level limit modes hold the counter reset at the selected input level.
// R8 - Level limit modes ignore the external input while the run bit is clear.
// R9 - Level reset comes at period match or two clocks into an active level.
// R10 - Counting and PWM high restart after match or two clocks after release.
// R11 - Level modes raise PWM when counting starts, lower it at compare.
// R12 - PWM high during a level reset stays high until compare after release.
// R13 - Software one-shot: period match resets counter and clears the run bit.
// R14 - Software must set the run bit again for each further one-shot cycle.
// R15 - Software one-shot: stopping and restarting mid-cycle pauses, then resumes.
// R16 - Software one-shot PWM starts with run bit, ends at compare, stretches.
// R17 - Edge one-shot starts on the chosen edge once running; match clears run.
// R18 - Edge one-shot halted by software needs a fresh edge to resume.
// R19 - Edge one-shot PWM rises on starting edge, falls at compare, stays low.
// R20 - Run bit and external input are synchronised with two or more clocks.
// R21 - Clearing the run bit returns the sequencing state to its reset state.
// R22 - One-shot end: clock after match clears run bit, stops counter at zero.
// R23 - Reserved mode codes keep the counter idle and the PWM inactive.
`ifndef PT_DEFINES_SVH
`define PT_DEFINES_SVH

// Register indices on the plain register port.
`define PT_ADDR_CTRL    2'h0
`define PT_ADDR_PERIOD  2'h1
`define PT_ADDR_CMP     2'h2
`define PT_ADDR_COUNT   2'h3

// Control register layout.
`define PT_CTRL_ON      7
`define PT_MODE_MSB     4
`define PT_MODE_LSB     0

// Mode codes.
`define PT_M_SWGATE     5'h00
`define PT_M_GATE_HI    5'h01
`define PT_M_GATE_LO    5'h02
`define PT_M_EDGE_ANY   5'h03
`define PT_M_EDGE_RISE  5'h04
`define PT_M_EDGE_FALL  5'h05
`define PT_M_LVL_LOW    5'h06
`define PT_M_LVL_HIGH   5'h07
`define PT_M_OS_SW      5'h08
`define PT_M_OS_RISE    5'h09
`define PT_M_OS_FALL    5'h0A
`define PT_M_OS_ANY     5'h0B

// Timing counts in timer clocks.
`define PT_RESTART_DLY  2'h2
`define PT_LEVEL_DLY    2'h2

// Synchroniser lanes.
`define PT_SYNC_EXT     0
`define PT_SYNC_ON      1

// Zero and one constants.
`define PT_ZERO8        8'h00
`define PT_ZERO2        2'h0
`define PT_ONE2         2'h1

`endif

// >>> verilog/pt_pkg.sv
`default_nettype none

package pt_pkg;

  // Behaviour class of a mode code.
  typedef enum logic [2:0] {
    PT_K_RSVD,
    PT_K_FREE,
    PT_K_GATE,
    PT_K_EDGE,
    PT_K_LEVEL,
    PT_K_OS,
    PT_K_EOS
  } pt_kind_t;

  // Whole state of the timer core.
  typedef struct packed {
    logic       on;
    logic [4:0] mode;
    logic [7:0] per;
    logic [7:0] cmp;
    logic [7:0] cnt;
    logic       pwm;
    logic       armed;
    logic       done;
    logic [1:0] dly;
    logic [1:0] act;
    logic       on_prev;
    logic [7:0] rdata;
  } pt_state_t;

endpackage

`default_nettype wire

// >>> verilog/pt_sync_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pt_sync_if #(
  parameter int W = 2
);
  logic [W-1:0] raw;
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  logic [W-1:0] fall;

  modport sync_side (input raw, output lvl, output rise, output fall);
  modport user_side (output raw, input lvl, input rise, input fall);
endinterface

`default_nettype wire

// >>> verilog/pt_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pt_sync
  import pt_pkg::*;
#(
  parameter int W = 2
) (
  input wire logic mclk,
  input wire logic rst,
  pt_sync_if.sync_side sif
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } pt_sync_st_t;

  pt_sync_st_t q;
  pt_sync_st_t n;

  // Three stages per lane; a change is taken once stages two and three
  // agree, so a single metastable sample never produces a false edge.
  always_comb begin
    n = q;
    for (int i = 0; i < W; i++) begin
      n.s1[i] = sif.raw[i];
      n.s2[i] = q.s1[i];
      n.s3[i] = q.s2[i];
      if (q.s2[i] == q.s3[i]) begin
        n.lvl[i] = q.s3[i];
      end
      n.rise[i] = n.lvl[i] & ~q.lvl[i];
      n.fall[i] = ~n.lvl[i] & q.lvl[i];
    end
  end

  // Single register for the whole state.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // Outputs come straight from the registered state.
  assign sif.lvl  = q.lvl;
  assign sif.rise = q.rise;
  assign sif.fall = q.fall;

endmodule // pt_sync

`default_nettype wire

// >>> tb/pt_ext_model.sv
`timescale 1ns/1ps
`default_nettype none

module pt_ext_model (
  input  wire logic       mclk,
  input  wire logic       lvl_req,
  input  wire logic [1:0] lag,
  output var  logic       ext_reset_input
);
  logic [3:0] pipe_q = 4'h0;

  // The source follows its request one to four clocks late,
  // since an upstream peripheral is free-running against the timer.
  always @(posedge mclk) begin
    pipe_q <= {pipe_q[2:0], lvl_req};
  end

  assign ext_reset_input = pipe_q[lag];
endmodule // pt_ext_model

`default_nettype wire

// >>> tb/period_timer_hw_limit_modes_bench.sv
`timescale 1ns/1ps
`default_nettype none

module period_timer_hw_limit_modes_bench;
  logic       mclk;
  logic       rst;
  logic       ext_req;
  logic       ext_reset_input;
  logic [1:0] lag;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       pwm_out;
  logic [7:0] rv;
  logic [7:0] a;
  int         h;
  int         pwm_hi = 0;
  int         mismatches = 0;
  int         cmp_count = 0;

  pt_timer u_dut (
    .mclk            (mclk),
    .rst             (rst),
    .ext_reset_input (ext_reset_input),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .pwm_out         (pwm_out)
  );

  pt_ext_model u_src (
    .mclk            (mclk),
    .lvl_req         (ext_req),
    .lag             (lag),
    .ext_reset_input (ext_reset_input)
  );

  // Clock of 4 ns period.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Counts cycles of high drive, so a short pulse is never missed.
  always @(posedge mclk) begin
    if (pwm_out === 1'b1) pwm_hi <= pwm_hi + 1;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wr(input logic [1:0] ad, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= ad;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [1:0] ad, output logic [7:0] d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= ad;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Stop the timer, let the run bit pass the synchroniser, clear count.
  task automatic idle;
    wr(2'h0, 8'h00);
    cyc(6);
    wr(2'h3, 8'h00);
  endtask

  // Bounded wait for the hardware to drop the run bit.
  task automatic wait_off;
    for (int i = 0; i < 40; i++) begin
      rd(2'h0, rv);
      if (rv[7] === 1'b0) return;
    end
    mismatches++;
    $display("ERROR %0t: run bit stuck", $time);
    report_and_stop;
  endtask

  task automatic t_reset;
    for (int i = 0; i < 4; i++) begin
      rd(2'(i), rv);
      check(rv, 8'h00);
    end
    check({7'h0, pwm_out}, 8'h00);
    wr(2'h0, 8'hFF);
    rd(2'h0, rv);
    check(rv, 8'h9F);
    cyc(10);
    #1;
    check({7'h0, pwm_out}, 8'h00);
  endtask

  // Reads come every two clocks, so the count steps by two modulo six.
  task automatic t_swgate;
    idle;
    wr(2'h1, 8'h05);
    wr(2'h0, 8'h80);
    cyc(8);
    rd(2'h3, a);
    repeat (6) begin
      rd(2'h3, rv);
      check(rv, (a >= 8'h04) ? a - 8'h04 : a + 8'h02);
      a = rv;
    end
    wr(2'h0, 8'h00);
    cyc(6);
    rd(2'h3, a);
    cyc(10);
    rd(2'h3, rv);
    check(rv, a);
  endtask

  task automatic t_gate;
    for (int m = 1; m <= 2; m++) begin
      ext_req <= (m == 1);
      idle;
      wr(2'h1, 8'hFF);
      wr(2'h0, 8'h80 | 8'(m));
      cyc(10);
      rd(2'h3, rv);
      check(rv, 8'h00);
      ext_req <= (m != 1);
      cyc(10);
      rd(2'h3, rv);
      check({7'h0, rv > 8'h00}, 8'h01);
    end
  endtask

  // Without the edge the count would be near 60 and the pulse long over.
  task automatic t_edge;
    for (int m = 3; m <= 5; m++) begin
      ext_req <= (m == 5);
      lag     <= 2'(m - 3);
      idle;
      wr(2'h1, 8'hC8);
      wr(2'h2, 8'h20);
      wr(2'h0, 8'h80 | 8'(m));
      cyc(50);
      ext_req <= (m != 5);
      cyc(12);
      rd(2'h3, rv);
      check({7'h0, rv < 8'h0C}, 8'h01);
      check({7'h0, pwm_out}, 8'h01);
    end
  endtask

  task automatic t_level;
    ext_req <= 1'b1;
    lag     <= 2'h0;
    idle;
    wr(2'h1, 8'hC8);
    wr(2'h2, 8'h20);
    wr(2'h0, 8'h87);
    cyc(20);
    rd(2'h3, rv);
    check(rv, 8'h00);
    ext_req <= 1'b0;
    cyc(12);
    rd(2'h3, rv);
    check({7'h0, rv != 8'h00 && rv < 8'h10}, 8'h01);
    check({7'h0, pwm_out}, 8'h01);
    cyc(40);
    #1;
    check({7'h0, pwm_out}, 8'h00);
    ext_req <= 1'b1;
    cyc(12);
    rd(2'h3, rv);
    check(rv, 8'h00);
  endtask

  task automatic t_oneshot;
    ext_req <= 1'b0;
    idle;
    wr(2'h1, 8'h03);
    wr(2'h2, 8'h01);
    for (int k = 0; k < 2; k++) begin
      h = pwm_hi;
      wr(2'h0, 8'h88);
      wait_off;
      rd(2'h0, rv);
      check(rv, 8'h08);
      rd(2'h3, rv);
      check(rv, 8'h00);
      check({7'h0, pwm_hi > h}, 8'h01);
      check({7'h0, pwm_out}, 8'h00);
    end
  endtask

  // The run bit is set well before any edge, so the timer must sit at
  // zero, still running and with PWM low, until the chosen edge arrives.
  task automatic t_edge_os;
    lag <= 2'h3;
    for (int m = 9; m <= 11; m++) begin
      ext_req <= (m == 10);
      idle;
      wr(2'h0, 8'h80 | 8'(m));
      cyc(20);
      rd(2'h3, rv);
      check(rv, 8'h00);
      check({7'h0, pwm_out}, 8'h00);
      rd(2'h0, rv);
      check(rv, 8'h80 | 8'(m));
      h = pwm_hi;
      ext_req <= (m != 10);
      wait_off;
      rd(2'h3, rv);
      check(rv, 8'h00);
      check({7'h0, pwm_hi > h}, 8'h01);
      check({7'h0, pwm_out}, 8'h00);
    end
  endtask

  task automatic t_reserved;
    idle;
    wr(2'h3, 8'h05);
    wr(2'h0, 8'h8C);
    cyc(20);
    rd(2'h3, rv);
    check(rv, 8'h05);
    check({7'h0, pwm_out}, 8'h00);
  endtask

  // A hang anywhere ends the run as a failure.
  initial begin
    #100000;
    mismatches++;
    $display("ERROR %0t: watchdog expired", $time);
    report_and_stop;
  end

  initial begin
    rst       = 1'b1;
    ext_req   = 1'b0;
    lag       = 2'h0;
    reg_addr  = 2'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    cyc(6);
    rst <= 1'b0;
    t_reset;
    t_swgate;
    t_gate;
    t_edge;
    t_level;
    t_oneshot;
    t_edge_os;
    t_reserved;
    report_and_stop;
  end
endmodule // period_timer_hw_limit_modes_bench

`default_nettype wire
